// File: hw/gsm_pkg.sv
package gsm_pkg;
  // pin count and bus widths
  localparam int GSM_NPINS = 3;
  localparam int GSM_AW = 8;
  localparam int GSM_DW = 32;

  // register byte offsets
  localparam logic [GSM_AW-1:0] GSM_OFS_DIR = 8'h00;
  localparam logic [GSM_AW-1:0] GSM_OFS_DATA = 8'h04;
  localparam logic [GSM_AW-1:0] GSM_OFS_GENCTL = 8'h08;
  localparam logic [GSM_AW-1:0] GSM_OFS_STATUS = 8'h0C;

  // direction register: bit n is pin n, one selects output
  localparam int GSM_DIR_PIN_ZERO = 0;
  localparam int GSM_DIR_PIN_ONE = 1;
  localparam int GSM_DIR_PIN_TWO = 2;
  localparam logic [GSM_NPINS-1:0] GSM_DIR_RST = 3'h0;
  localparam logic [GSM_NPINS-1:0] GSM_DOUT_RST = 3'h0;

  // general control fields
  localparam int GSM_GEN_CRM_BIT = 0;
  localparam int GSM_GEN_OVR_LSB = 20;
  localparam int GSM_GEN_OVR_MSB = 22;
  localparam logic [2:0] GSM_OVR_RST = 3'h0;
  localparam logic [2:0] GSM_OVR_CODE_A = 3'h1;
  localparam logic [2:0] GSM_OVR_CODE_B = 3'h3;

  // status fields
  localparam int GSM_ST_CLK_STRAP = 0;
  localparam int GSM_ST_ARB_STRAP = 1;
  localparam int GSM_ST_CRM_ACT = 2;
  localparam int GSM_ST_OVR_ACT = 3;
  localparam int GSM_ST_CLK_REQ = 4;

  // pins that carry an alternate function
  localparam int GSM_PIN_CRUN = 0;
  localparam int GSM_PIN_OVR = 1;

  // apb request and answer
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [GSM_AW-1:0] paddr;
    logic [GSM_DW-1:0] pwdata;
  } gsm_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [GSM_DW-1:0] prdata;
  } gsm_apb_rsp_t;

  // pad drive for all general pins
  typedef struct packed {
    logic [GSM_NPINS-1:0] out;
    logic [GSM_NPINS-1:0] oe;
    logic [GSM_NPINS-1:0] pullup_en;
  } gsm_pad_t;
endpackage : gsm_pkg

// File: hw/gsm_pin_cell.sv
module gsm_pin_cell
  import gsm_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // software setting
  input wire logic dir,
  input wire logic dout,
  // alternate function
  input wire logic alt_en,
  input wire logic alt_oe,
  input wire logic alt_out,
  // pad
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic pullup_en,
  // readback
  output logic in_smp,
  output logic rd_bit
);
  logic pin_out_ff, nxt_pin_out;
  logic pin_oe_ff, nxt_pin_oe;
  logic in_smp_ff, nxt_in_smp;
  logic rd_bit_ff, nxt_rd_bit;

  // pick drive from software or alternate function
  always_comb begin
    nxt_pin_oe = alt_en ? alt_oe : dir;
    nxt_pin_out = alt_en ? alt_out : (dir & dout);
    nxt_in_smp = pin_in;
    nxt_rd_bit = dir ? dout : pin_in;
  end

  // pad registers, released to input during reset
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pin_oe_ff <= 1'b0;
      pin_out_ff <= 1'b0;
      in_smp_ff <= 1'b0;
      rd_bit_ff <= 1'b0;
    end else begin
      pin_oe_ff <= nxt_pin_oe;
      pin_out_ff <= nxt_pin_out;
      in_smp_ff <= nxt_in_smp;
      rd_bit_ff <= nxt_rd_bit;
    end
  end

  assign pin_out = pin_out_ff;
  assign pin_oe = pin_oe_ff;
  assign in_smp = in_smp_ff;
  assign rd_bit = rd_bit_ff;
  // pullup only in reset or while the pad is an input
  assign pullup_en = !rst_b || !pin_oe_ff;
endmodule : gsm_pin_cell

// File: hw/gsm_pin_mux.sv
module gsm_pin_mux
  import gsm_pkg::*;
#(
  parameter int NPINS = GSM_NPINS
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // apb slave
  input wire gsm_apb_req_t apb_req,
  output gsm_apb_rsp_t apb_rsp,
  // general pins
  input wire logic [NPINS-1:0] general_io_pin_in,
  output gsm_pad_t general_io_pad,
  // straps
  input wire logic clock_stop_support_strap,
  input wire logic arbiter_source_strap,
  // core side
  input wire logic power_override_level,
  output logic clock_stop_request_input,
  output logic clock_run_mode_active,
  output logic clock_stop_support_en,
  output logic external_arbiter_sel
);
  // software registers
  logic [NPINS-1:0] pin_direction_ff, nxt_pin_direction;
  logic [NPINS-1:0] pin_dout_ff, nxt_pin_dout;
  logic [2:0] power_override_select_ff, nxt_power_override_select;
  logic crm_enable_ff, nxt_crm_enable;
  logic [GSM_DW-1:0] prdata_ff, nxt_prdata;

  // strap capture state
  logic strap_done_ff, nxt_strap_done;
  logic clk_strap_ff, nxt_clk_strap;
  logic arb_strap_ff, nxt_arb_strap;

  // mux decisions
  logic override_on;
  logic crm_on;
  logic [NPINS-1:0] alt_en;
  logic [NPINS-1:0] alt_oe;
  logic [NPINS-1:0] alt_out;
  logic [NPINS-1:0] in_smp;
  logic [NPINS-1:0] rd_bits;

  // bus decode
  logic setup_ph;
  logic wr_fire;
  logic hit_dir;
  logic hit_data;
  logic hit_gen;
  logic hit_st;
  logic mapped;

  // names of the three direction bits
  logic pin_zero_direction;
  logic pin_one_direction;
  logic pin_two_direction;

  assign pin_zero_direction = pin_direction_ff[GSM_DIR_PIN_ZERO];
  assign pin_one_direction = pin_direction_ff[GSM_DIR_PIN_ONE];
  assign pin_two_direction = pin_direction_ff[GSM_DIR_PIN_TWO];

  // address decode, one aligned word per register
  always_comb begin
    hit_dir = (apb_req.paddr == GSM_OFS_DIR);
    hit_data = (apb_req.paddr == GSM_OFS_DATA);
    hit_gen = (apb_req.paddr == GSM_OFS_GENCTL);
    hit_st = (apb_req.paddr == GSM_OFS_STATUS);
    mapped = hit_dir | hit_data | hit_gen | hit_st;
    setup_ph = apb_req.psel & ~apb_req.penable;
    wr_fire = apb_req.psel & apb_req.penable & apb_req.pwrite;
  end

  // zero-wait slave; unmapped access answers with an error
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~mapped;
  assign apb_rsp.prdata = prdata_ff;

  // power override field decode
  always_comb begin
    override_on = (power_override_select_ff == GSM_OVR_CODE_A) ||
                  (power_override_select_ff == GSM_OVR_CODE_B);
  end

  // clock-run mode needs the strap high and software enable
  assign crm_on = clk_strap_ff & crm_enable_ff;

  // alternate function per pin
  always_comb begin
    alt_en = '0;
    alt_oe = '0;
    alt_out = '0;
    // pin zero becomes an input for the clock-stop request
    alt_en[GSM_PIN_CRUN] = crm_on;
    alt_oe[GSM_PIN_CRUN] = 1'b0;
    // pin one drives the power override level
    alt_en[GSM_PIN_OVR] = override_on;
    alt_oe[GSM_PIN_OVR] = 1'b1;
    alt_out[GSM_PIN_OVR] = power_override_level;
    // pin two keeps no alternate use
  end

  // one pad cell per general pin
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_pin
      gsm_pin_cell u_cell (
        .mclk(mclk),
        .rst_b(rst_b),
        .dir(pin_direction_ff[gi]),
        .dout(pin_dout_ff[gi]),
        .alt_en(alt_en[gi]),
        .alt_oe(alt_oe[gi]),
        .alt_out(alt_out[gi]),
        .pin_in(general_io_pin_in[gi]),
        .pin_out(general_io_pad.out[gi]),
        .pin_oe(general_io_pad.oe[gi]),
        .pullup_en(general_io_pad.pullup_en[gi]),
        .in_smp(in_smp[gi]),
        .rd_bit(rd_bits[gi])
      );
    end
  endgenerate

  // clock-stop request follows pin zero only in clock-run mode
  assign clock_stop_request_input = in_smp[GSM_PIN_CRUN] & crm_on;
  assign clock_run_mode_active = crm_on;

  // strap levels picked up once, in the first cycle after reset release
  always_comb begin
    nxt_strap_done = 1'b1;
    nxt_clk_strap = clk_strap_ff;
    nxt_arb_strap = arb_strap_ff;
    if (!strap_done_ff) begin
      nxt_clk_strap = clock_stop_support_strap;
      nxt_arb_strap = arbiter_source_strap;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      strap_done_ff <= 1'b0;
      clk_strap_ff <= 1'b0;
      arb_strap_ff <= 1'b0;
    end else begin
      strap_done_ff <= nxt_strap_done;
      clk_strap_ff <= nxt_clk_strap;
      arb_strap_ff <= nxt_arb_strap;
    end
  end

  // low strap: support off, internal arbiter; high: support on, external
  assign clock_stop_support_en = clk_strap_ff;
  assign external_arbiter_sel = arb_strap_ff;

  // register writes at the access phase
  always_comb begin
    nxt_pin_direction = pin_direction_ff;
    nxt_pin_dout = pin_dout_ff;
    nxt_power_override_select = power_override_select_ff;
    nxt_crm_enable = crm_enable_ff;
    if (wr_fire) begin
      if (hit_dir) begin
        nxt_pin_direction = apb_req.pwdata[NPINS-1:0];
      end
      if (hit_data) begin
        nxt_pin_dout = apb_req.pwdata[NPINS-1:0];
      end
      if (hit_gen) begin
        nxt_power_override_select = apb_req.pwdata[GSM_GEN_OVR_MSB:GSM_GEN_OVR_LSB];
        nxt_crm_enable = apb_req.pwdata[GSM_GEN_CRM_BIT];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pin_direction_ff <= GSM_DIR_RST;
      pin_dout_ff <= GSM_DOUT_RST;
      power_override_select_ff <= GSM_OVR_RST;
      crm_enable_ff <= 1'b0;
    end else begin
      pin_direction_ff <= nxt_pin_direction;
      pin_dout_ff <= nxt_pin_dout;
      power_override_select_ff <= nxt_power_override_select;
      crm_enable_ff <= nxt_crm_enable;
    end
  end

  // read data prepared in the setup phase, held for the access phase
  always_comb begin
    nxt_prdata = prdata_ff;
    if (setup_ph) begin
      nxt_prdata = '0;
      if (hit_dir) begin
        nxt_prdata[NPINS-1:0] = pin_direction_ff;
      end
      if (hit_data) begin
        nxt_prdata[NPINS-1:0] = rd_bits;
      end
      if (hit_gen) begin
        nxt_prdata[GSM_GEN_OVR_MSB:GSM_GEN_OVR_LSB] = power_override_select_ff;
        nxt_prdata[GSM_GEN_CRM_BIT] = crm_enable_ff;
      end
      if (hit_st) begin
        nxt_prdata[GSM_ST_CLK_STRAP] = clk_strap_ff;
        nxt_prdata[GSM_ST_ARB_STRAP] = arb_strap_ff;
        nxt_prdata[GSM_ST_CRM_ACT] = crm_on;
        nxt_prdata[GSM_ST_OVR_ACT] = override_on;
        nxt_prdata[GSM_ST_CLK_REQ] = clock_stop_request_input;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      prdata_ff <= '0;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end
endmodule : gsm_pin_mux

// File: tb/gsm_pin_mux_properties.sv
module gsm_pin_mux_properties
  import gsm_pkg::*;
#(
  parameter int NPINS = GSM_NPINS
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // apb
  input wire gsm_apb_req_t apb_req,
  input wire gsm_apb_rsp_t apb_rsp,
  // pins and straps
  input wire logic [NPINS-1:0] general_io_pin_in,
  input wire gsm_pad_t general_io_pad,
  input wire logic clock_stop_support_strap,
  input wire logic arbiter_source_strap,
  // core side
  input wire logic power_override_level,
  input wire logic clock_stop_request_input,
  input wire logic clock_run_mode_active,
  input wire logic clock_stop_support_en,
  input wire logic external_arbiter_sel
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic [2:0] dir_ff, dat_ff, ovr_ff, nxt_dir, nxt_dat, nxt_ovr;
  logic wr, osel;
  // shadow of software writes
  always_comb begin
    wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
    nxt_dir = (wr && apb_req.paddr == GSM_OFS_DIR) ? apb_req.pwdata[2:0] : dir_ff;
    nxt_dat = (wr && apb_req.paddr == GSM_OFS_DATA) ? apb_req.pwdata[2:0] : dat_ff;
    nxt_ovr = (wr && apb_req.paddr == GSM_OFS_GENCTL) ? apb_req.pwdata[22:20] : ovr_ff;
    osel = (ovr_ff == GSM_OVR_CODE_A) || (ovr_ff == GSM_OVR_CODE_B);
  end
  always_ff @(posedge mclk) begin
    dir_ff <= rst_b ? nxt_dir : 3'h0;
    dat_ff <= rst_b ? nxt_dat : 3'h0;
    ovr_ff <= rst_b ? nxt_ovr : 3'h0;
  end
  pull_en_a: assert property (disable iff (1'b0)
    general_io_pad.pullup_en == (~general_io_pad.oe | {GSM_NPINS{!rst_b}}))
    else $error("pullup enable wrong");
  pin0_dir_a: assert property (!$past(clock_run_mode_active) |->
    general_io_pad.oe[0] == $past(dir_ff[0]) && general_io_pad.out[0] == $past(dir_ff[0] & dat_ff[0]))
    else $error("pin zero drive wrong");
  crun_in_a: assert property ($past(clock_run_mode_active) |-> !general_io_pad.oe[0])
    else $error("pin zero driven in clock-run mode");
  stop_req_a: assert property (clock_run_mode_active == $past(clock_run_mode_active) |->
    clock_stop_request_input == ($past(general_io_pin_in[0]) & clock_run_mode_active))
    else $error("clock-stop request wrong");
  pin1_dir_a: assert property (!$past(osel) |-> general_io_pad.oe[1] == $past(dir_ff[1]))
    else $error("pin one direction wrong");
  ovr_drive_a: assert property ($past(osel) |->
    general_io_pad.oe[1] && general_io_pad.out[1] == $past(power_override_level))
    else $error("override output wrong");
  pin2_dir_a: assert property (general_io_pad.oe[2] == $past(dir_ff[2]) &&
    general_io_pad.out[2] == $past(dir_ff[2] & dat_ff[2]))
    else $error("pin two drive wrong");
  strap_cap_a: assert property ($rose(rst_b) |=>
    clock_stop_support_en == $past(clock_stop_support_strap) &&
    external_arbiter_sel == $past(arbiter_source_strap))
    else $error("strap capture wrong");
  crm_gate_a: assert property (clock_run_mode_active |-> clock_stop_support_en)
    else $error("clock-run mode without support");
  // main scenarios reached
  cover property (osel);
  cover property (clock_stop_request_input);
  cover property (external_arbiter_sel);
endmodule : gsm_pin_mux_properties

bind gsm_pin_mux gsm_pin_mux_properties #(.NPINS(NPINS)) u_props (
  .mclk(mclk), .rst_b(rst_b), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .general_io_pin_in(general_io_pin_in), .general_io_pad(general_io_pad),
  .clock_stop_support_strap(clock_stop_support_strap),
  .arbiter_source_strap(arbiter_source_strap),
  .power_override_level(power_override_level),
  .clock_stop_request_input(clock_stop_request_input),
  .clock_run_mode_active(clock_run_mode_active),
  .clock_stop_support_en(clock_stop_support_en),
  .external_arbiter_sel(external_arbiter_sel));

// File: tb/gsm_board_model.sv
module gsm_board_model
  import gsm_pkg::*;
(
  // clock
  input wire logic mclk,
  // device pads and board drivers
  input wire gsm_pad_t pad,
  input wire logic [2:0] ext_en,
  input wire logic [2:0] ext_val,
  output logic [2:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tog_ff = 1'b0;
  // floating level keeps changing
  always @(posedge mclk) begin
    tog_ff <= ~tog_ff;
  end
  // wire level: device, then board, then pullup, else floating
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin_in[i] = pad.oe[i] ? pad.out[i] : ext_en[i] ? ext_val[i] :
        pad.pullup_en[i] ? 1'b1 : tog_ff;
    end
  end
endmodule : gsm_board_model

// File: tb/gsm_pin_mux_tb_top.sv
module gsm_pin_mux_tb_top import gsm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_b, cs_strap, arb_strap, ovr_lvl, crq, crm, cse, exa, s, e;
  logic [2:0] pin_in, ext_en, ext_val;
  logic [31:0] q;
  gsm_apb_req_t req;
  gsm_apb_rsp_t rsp;
  gsm_pad_t pad;
  int err_total, cmp_count;
  gsm_pin_mux dut (.mclk(mclk), .rst_b(rst_b), .apb_req(req), .apb_rsp(rsp),
    .general_io_pin_in(pin_in), .general_io_pad(pad), .clock_stop_support_strap(cs_strap),
    .arbiter_source_strap(arb_strap), .power_override_level(ovr_lvl),
    .clock_stop_request_input(crq), .clock_run_mode_active(crm),
    .clock_stop_support_en(cse), .external_arbiter_sel(exa));
  gsm_board_model board (.mclk(mclk), .pad(pad), .ext_en(ext_en), .ext_val(ext_val),
    .pin_in(pin_in));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge mclk);
    req.penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      end_of_test();
    end
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic rst(input logic c, input logic a);
    @(posedge mclk);
    rst_b <= 1'b0;
    cs_strap <= c;
    arb_strap <= a;
    cyc(3);
    chk("pullup rst", 32'h7, pad.pullup_en);
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    cyc(2);
    chk("straps", {c, a}, {cse, exa});
  endtask : rst
  task automatic end_of_test;
    $display("comparisons %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  // watchdog
  initial begin
    #20000;
    err_total++;
    end_of_test();
  end
  // main sequence
  initial begin
    rst_b = 1'b0;
    {cs_strap, arb_strap, ovr_lvl, ext_en, ext_val, req} = '0;
    rst(1'b1, 1'b0);
    apb(1'b1, GSM_OFS_DIR, 32'h5);
    apb(1'b1, GSM_OFS_DATA, 32'h7);
    ext_en <= 3'h2;
    cyc(2);
    chk("oe", 32'h5, pad.oe);
    chk("out", 32'h5, pad.out);
    chk("pullup", 32'h2, pad.pullup_en);
    apb(1'b0, GSM_OFS_DATA, 32'h0);
    chk("data", 32'h5, q);
    chk("data err", 32'h0, e);
    apb(1'b0, GSM_OFS_DIR, 32'h0);
    chk("dir", 32'h5, q);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, GSM_OFS_GENCTL, 32'(c) << 20);
      ovr_lvl <= c[1];
      s = (c == 1 || c == 3);
      cyc(2);
      chk("pin one", {s, s & c[1]}, {pad.oe[1], pad.out[1]});
    end
    apb(1'b1, GSM_OFS_GENCTL, 32'h1);
    ext_en <= 3'h3;
    ext_val <= 3'h1;
    cyc(3);
    chk("clock run", 32'h5, {crm, pad.oe[0], crq});
    apb(1'b0, GSM_OFS_STATUS, 32'h0);
    chk("status", 32'h15, q[4:0]);
    ext_val <= 3'h0;
    cyc(2);
    chk("stop request", 32'h0, crq);
    rst(1'b0, 1'b1);
    apb(1'b1, GSM_OFS_GENCTL, 32'h1);
    cyc(2);
    chk("mode off", 32'h0, crm);
    chk("pullup in", 32'h7, pad.pullup_en);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, q);
    chk("unmapped err", 32'h1, e);
    end_of_test();
  end
endmodule : gsm_pin_mux_tb_top
